/* fpm_mul_neq_unit.sv */
module fpm_mul_neq_unit
    import fpm_pkg::*;
#(
    parameter int MUL_LAT = FPM_MUL_LATENCY
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire fpm_issue_t issue_slot2,
    input wire fpm_issue_t issue_slot3,
    input wire logic [1:0] rounding_mode,
    input wire logic status_write_valid,
    input wire logic [FPM_FLAG_W-1:0] status_write_flags,
    input wire logic [FPM_FLAG_W-1:0] other_unit_flags,
    output fpm_wb_t mul_wb_slot2,
    output fpm_wb_t mul_wb_slot3,
    output fpm_wb_t cmp_wb,
    output logic [FPM_FLAG_W-1:0] exception_flags
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Guard gate; a missing guard acts as a true one
    // A clear guard bit leaves destination and status alone
    function automatic logic fpm_guard_ok(input fpm_issue_t op);
        return !op.guarded || op.guard_lsb;
    endfunction : fpm_guard_ok

    // Nonzero fraction under a zero exponent; flushed to zero on entry
    function automatic logic fpm_is_denorm(input logic [31:0] v);
        return v[30:23] == 8'h00 && v[22:0] != 23'h000000;
    endfunction : fpm_is_denorm

    // All-ones exponent with a nonzero fraction
    function automatic logic fpm_is_nan(input logic [31:0] v);
        return v[30:23] == FPM_EXP_SPECIAL && v[22:0] != 23'h000000;
    endfunction : fpm_is_nan

    // A NaN whose top fraction bit is clear signals; the quiet kind
    // passes through without raising a bad-operation flag
    function automatic logic fpm_is_snan(input logic [31:0] v);
        return fpm_is_nan(v) && !v[22];
    endfunction : fpm_is_snan

    // Exceptions a single-precision multiply would raise
    function automatic logic [FPM_FLAG_W-1:0] fpm_mul_flags(
        input logic [31:0] a,
        input logic [31:0] b,
        input logic [1:0] rm
    );
        logic [7:0] ea;
        logic [7:0] eb;
        logic [22:0] fa;
        logic [22:0] fb;
        logic za;
        logic zb;
        logic ia;
        logic ib;
        logic na;
        logic nb;
        logic sign;
        logic [47:0] prod;
        logic signed [10:0] exp;
        logic signed [10:0] exp_rnd;
        logic [23:0] sig;
        logic rbit;
        logic sbit;
        logic up;
        logic tiny_up;
        logic [FPM_FLAG_W-1:0] f;
        f = FPM_FLAGS_RST;
        ea = a[30:23];
        eb = b[30:23];
        fa = a[22:0];
        fb = b[22:0];
        sign = a[31] ^ b[31];
        // Bit 0 stays clear; only the six exception bits are ever set
        // Denormals are treated as zero and reported
        if (fpm_is_denorm(a)) begin
            f[FPM_BIT_INPUT_FLUSHED] = 1'b1;
        end
        if (fpm_is_denorm(b)) begin
            f[FPM_BIT_INPUT_FLUSHED] = 1'b1;
        end
        za = (ea == 8'h00);
        zb = (eb == 8'h00);
        ia = (ea == FPM_EXP_SPECIAL) && (fa == 23'h000000);
        ib = (eb == FPM_EXP_SPECIAL) && (fb == 23'h000000);
        na = fpm_is_nan(a);
        nb = fpm_is_nan(b);
        // Significand product and normalisation
        prod = {1'b1, fa} * {1'b1, fb};
        exp = signed'({3'b000, ea}) + signed'({3'b000, eb}) - FPM_EXP_BIAS;
        if (prod[47]) begin
            sig = prod[47:24];
            rbit = prod[23];
            sbit = |prod[22:0];
            exp = exp + 11'sh001;
        end else begin
            sig = prod[46:23];
            rbit = prod[22];
            sbit = |prod[21:0];
        end
        // Rounding direction from the status word mode
        case (rm)
            FPM_RM_NEAREST: up = rbit && (sbit || sig[0]);
            FPM_RM_PLUS: up = (rbit || sbit) && !sign;
            FPM_RM_MINUS: up = (rbit || sbit) && sign;
            default: up = 1'b0;
        endcase
        // Directed rounding away from zero lifts even the tiniest product
        tiny_up = (rm == FPM_RM_PLUS && !sign) ||
                  (rm == FPM_RM_MINUS && sign);
        // A carry out of rounding can push a finite product over the top
        exp_rnd = (up && &sig) ? exp + 11'sh001 : exp;
        if (na || nb) begin
            // Only a signalling NaN is invalid
            if (fpm_is_snan(a) || fpm_is_snan(b)) begin
                f[FPM_BIT_BAD_OPERATION] = 1'b1;
            end
        end else if ((ia && zb) || (ib && za)) begin
            f[FPM_BIT_BAD_OPERATION] = 1'b1;
        end else if (ia || ib || za || zb) begin
            f = f;  // Infinite or zero products are exact
        end else if (exp < FPM_EXP_MIN) begin
            // Tiny: flushing always loses the value
            f[FPM_BIT_UNDERFLOW] = 1'b1;
            f[FPM_BIT_INEXACT] = 1'b1;
            if (exp >= FPM_EXP_TINY || tiny_up) begin
                f[FPM_BIT_OUTPUT_FLUSHED] = 1'b1;
            end
        end else begin
            f[FPM_BIT_INEXACT] = rbit || sbit;
            if (exp_rnd >= FPM_EXP_OVERFLOW) begin
                f[FPM_BIT_OVERFLOW] = 1'b1;
                f[FPM_BIT_INEXACT] = 1'b1;
            end
        end
        return f;
    endfunction : fpm_mul_flags

    // Not-equal result in the top bit, its exceptions below
    function automatic logic [FPM_FLAG_W:0] fpm_neq(
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic [7:0] ea;
        logic [7:0] eb;
        logic na;
        logic nb;
        logic ne;
        logic [FPM_FLAG_W-1:0] f;
        f = FPM_FLAGS_RST;
        ea = a[30:23];
        eb = b[30:23];
        // A flushed denormal is a zero from here on
        if (fpm_is_denorm(a) || fpm_is_denorm(b)) begin
            f[FPM_BIT_INPUT_FLUSHED] = 1'b1;
        end
        na = fpm_is_nan(a);
        nb = fpm_is_nan(b);
        if (na || nb) begin
            // Unordered reads as not different; signalling NaN traps
            ne = 1'b0;
            if (fpm_is_snan(a) || fpm_is_snan(b)) begin
                f[FPM_BIT_BAD_OPERATION] = 1'b1;
            end
        end else if (ea == 8'h00 && eb == 8'h00) begin
            ne = 1'b0;  // Both zero after flushing, of either sign
        end else if (ea == 8'h00 || eb == 8'h00) begin
            ne = 1'b1;
        end else begin
            ne = (a != b);
        end
        return {ne, f};
    endfunction : fpm_neq

    // ************************************************************
    // Issue decode
    // ************************************************************
    // Index 0 is issue slot 2 and index 1 is issue slot 3
    fpm_issue_t mul_issue [2];
    logic mul_go [2];
    logic cmp_go;
    logic [FPM_FLAG_W:0] cmp_res;
    logic [FPM_FLAG_W-1:0] cmp_update;
    fpm_wb_t mul_pipe_r [2][MUL_LAT];
    fpm_wb_t cmp_wb_r;
    logic [FPM_FLAG_W-1:0] flags_r;
    logic [FPM_FLAG_W-1:0] flags_nxt;

    // Product query is legal in either slot, the compare only in slot 3
    assign mul_issue[0] = issue_slot2;
    assign mul_issue[1] = issue_slot3;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            mul_go[i] = mul_issue[i].valid &&
                        mul_issue[i].opcode == FPM_OPC_MUL_FLAGS &&
                        fpm_guard_ok(mul_issue[i]);
        end
    end

    // Slot 2 has no compare unit, so a compare there is ignored
    assign cmp_go = issue_slot3.valid &&
                    issue_slot3.opcode == FPM_OPC_NOT_EQUAL &&
                    fpm_guard_ok(issue_slot3);
    assign cmp_res = fpm_neq(issue_slot3.src1, issue_slot3.src2);
    // A refused compare feeds nothing into the status word
    assign cmp_update = cmp_go ? cmp_res[FPM_FLAG_W-1:0] : FPM_FLAGS_RST;

    // ************************************************************
    // Product query pipeline
    // ************************************************************

    // Flags are computed at issue and carried down a fixed delay line,
    // so the whole flag computation sits in front of the first stage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            // Clearing every stage keeps a stale valid from leaking out
            for (int i = 0; i < 2; i++) begin
                for (int s = 0; s < MUL_LAT; s++) begin
                    mul_pipe_r[i][s] <= '0;
                end
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                mul_pipe_r[i][0].valid <= mul_go[i];
                mul_pipe_r[i][0].dest <= mul_issue[i].dest;
                mul_pipe_r[i][0].data <= {25'h0,
                    fpm_mul_flags(mul_issue[i].src1, mul_issue[i].src2,
                                  rounding_mode)};
                for (int s = 1; s < MUL_LAT; s++) begin
                    mul_pipe_r[i][s] <= mul_pipe_r[i][s-1];
                end
            end
        end
    end

    // The last stage drives the writeback ports straight from flip-flops
    assign mul_wb_slot2 = mul_pipe_r[0][MUL_LAT-1];
    assign mul_wb_slot3 = mul_pipe_r[1][MUL_LAT-1];

    // ************************************************************
    // Not-equal compare, one cycle
    // ************************************************************
    // One register stage gives the single-cycle answer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmp_wb_r <= '0;
        end else begin
            cmp_wb_r.valid <= cmp_go;
            cmp_wb_r.dest <= issue_slot3.dest;
            cmp_wb_r.data <= {31'h0, cmp_res[FPM_FLAG_W]};
        end
    end

    // Registered, like every other output of the block
    assign cmp_wb = cmp_wb_r;

    // ************************************************************
    // Status word exception flags
    // ************************************************************

    // Explicit write is the only clear; updates OR on top so an event
    // landing in the clearing cycle survives. The product query never
    // feeds this path.
    always_comb begin
        flags_nxt = status_write_valid ? status_write_flags : flags_r;
        flags_nxt = flags_nxt | other_unit_flags | cmp_update;
    end

    // Same edge as the compare's destination write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flags_r <= FPM_FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign exception_flags = flags_r;

endmodule : fpm_mul_neq_unit

/* fpm_pkg.sv */
package fpm_pkg;

    // ************************************************************
    // Operation codes, latencies and widths
    // ************************************************************
    localparam logic [7:0] FPM_OPC_MUL_FLAGS = 8'h8f;   // 143
    localparam logic [7:0] FPM_OPC_NOT_EQUAL = 8'h96;   // 150
    localparam int FPM_MUL_LATENCY = 3;
    localparam int FPM_CMP_LATENCY = 1;
    localparam int FPM_DEST_W = 7;
    localparam int FPM_FLAG_W = 7;

    // ************************************************************
    // Exception bit positions, shared by status word and results
    // ************************************************************
    localparam int FPM_BIT_INEXACT = 1;
    localparam int FPM_BIT_UNDERFLOW = 2;
    localparam int FPM_BIT_OVERFLOW = 3;
    localparam int FPM_BIT_BAD_OPERATION = 4;
    localparam int FPM_BIT_INPUT_FLUSHED = 5;
    localparam int FPM_BIT_OUTPUT_FLUSHED = 6;
    localparam logic [FPM_FLAG_W-1:0] FPM_FLAGS_RST = 7'h00;

    // ************************************************************
    // Rounding mode codes and exponent limits
    // ************************************************************
    localparam logic [1:0] FPM_RM_NEAREST = 2'h0;
    localparam logic [1:0] FPM_RM_ZERO = 2'h1;
    localparam logic [1:0] FPM_RM_PLUS = 2'h2;
    localparam logic [1:0] FPM_RM_MINUS = 2'h3;
    localparam logic [7:0] FPM_EXP_SPECIAL = 8'hff;
    localparam logic signed [10:0] FPM_EXP_BIAS = 11'sh07f;
    localparam logic signed [10:0] FPM_EXP_OVERFLOW = 11'sh0ff;
    localparam logic signed [10:0] FPM_EXP_MIN = 11'sh001;
    // Below this biased exponent even a denormal rounds to zero
    localparam logic signed [10:0] FPM_EXP_TINY = -11'sh016;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic guarded;
        logic guard_lsb;
        logic [31:0] src1;
        logic [31:0] src2;
        logic [FPM_DEST_W-1:0] dest;
    } fpm_issue_t;

    typedef struct packed {
        logic valid;
        logic [FPM_DEST_W-1:0] dest;
        logic [31:0] data;
    } fpm_wb_t;

endpackage : fpm_pkg

/* fpm_mul_neq_assertions.sv */
module fpm_mul_neq_checker
    import fpm_pkg::*;
#(
    parameter int MUL_LAT = 3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire fpm_issue_t issue_slot2,
    input wire fpm_issue_t issue_slot3,
    input wire logic status_write_valid,
    input wire logic [FPM_FLAG_W-1:0] other_unit_flags,
    input wire fpm_wb_t mul_wb_slot2,
    input wire fpm_wb_t mul_wb_slot3,
    input wire fpm_wb_t cmp_wb,
    input wire logic [FPM_FLAG_W-1:0] exception_flags
);
    // ****************************************
    // Taken requests
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic m2_go, m3_go, c_go, dn1;
    // A missing guard counts as a true one
    assign m2_go = issue_slot2.valid && issue_slot2.opcode == FPM_OPC_MUL_FLAGS
        && (!issue_slot2.guarded || issue_slot2.guard_lsb);
    assign m3_go = issue_slot3.valid && issue_slot3.opcode == FPM_OPC_MUL_FLAGS
        && (!issue_slot3.guarded || issue_slot3.guard_lsb);
    assign c_go = issue_slot3.valid && issue_slot3.opcode == FPM_OPC_NOT_EQUAL
        && (!issue_slot3.guarded || issue_slot3.guard_lsb);
    // Either operand may be the denormal
    assign dn1 = (issue_slot3.src1[30:23] == 8'h00 && |issue_slot3.src1[22:0])
        || (issue_slot3.src2[30:23] == 8'h00 && |issue_slot3.src2[22:0]);
    property p_mul3;
        m3_go |-> ##MUL_LAT mul_wb_slot3.valid && mul_wb_slot3.data[31:7] == 0
            && mul_wb_slot3.dest == $past(issue_slot3.dest, MUL_LAT);
    endproperty
    a_mul3: assert property (p_mul3) // Timing
        else $error("slot 3 product result late or wrong");
    property p_mul2;
        m2_go |-> ##MUL_LAT mul_wb_slot2.valid
            && mul_wb_slot2.dest == $past(issue_slot2.dest, MUL_LAT);
    endproperty
    a_mul2: assert property (p_mul2) // Timing
        else $error("slot 2 product result late or wrong");
    property p_mulq;
        mul_wb_slot3.valid |-> $past(m3_go, MUL_LAT);
    endproperty
    a_mulq: assert property (p_mulq) // Guard
        else $error("product result without a taken issue");
    property p_cmp;
        c_go |=> cmp_wb.valid && cmp_wb.data[31:1] == 0
            && cmp_wb.dest == $past(issue_slot3.dest);
    endproperty
    a_cmp: assert property (p_cmp) // Timing
        else $error("compare result late or wrong");
    property p_cmpq;
        cmp_wb.valid |-> $past(c_go);
    endproperty
    a_cmpq: assert property (p_cmpq) // Guard
        else $error("compare result without a taken issue");
    property p_ifz;
        c_go && dn1 |=> exception_flags[FPM_BIT_INPUT_FLUSHED]
            && cmp_wb.valid;
    endproperty
    a_ifz: assert property (p_ifz) // Flush
        else $error("input flush flag not set with compare");
    property p_stick;
        !status_write_valid |=> (~exception_flags & $past(exception_flags)) == 0;
    endproperty
    a_stick: assert property (p_stick) // Sticky
        else $error("flag cleared without a status write");
    property p_or;
        other_unit_flags != 0 |=>
            (exception_flags & $past(other_unit_flags)) == $past(other_unit_flags);
    endproperty
    a_or: assert property (p_or) // Merge
        else $error("flags from other units lost");
    property p_quiet;
        !$stable(exception_flags) |->
            $past(status_write_valid || c_go || other_unit_flags != 0);
    endproperty
    a_quiet: assert property (p_quiet) // Query
        else $error("flags changed with no cause");
    c_both: cover property (m2_go && m3_go);
    c_neq: cover property (c_go ##1 cmp_wb.data[0]);
    c_clr: cover property (status_write_valid ##1 exception_flags == 0);
endmodule : fpm_mul_neq_checker

bind fpm_mul_neq_unit fpm_mul_neq_checker #(.MUL_LAT(MUL_LAT)) chk_inst (
    .sys_clk, .rst_n, .issue_slot2, .issue_slot3, .status_write_valid,
    .other_unit_flags, .mul_wb_slot2, .mul_wb_slot3, .cmp_wb, .exception_flags
);

/* fpm_regfile_model.sv */
module fpm_regfile_model
    import fpm_pkg::*;
(
    input wire logic sys_clk,
    input wire fpm_wb_t wb_a,
    input wire fpm_wb_t wb_b,
    input wire fpm_wb_t wb_c
);
    logic [31:0] regs [0:127];
    // Marker contents, so a write that should not happen stands out
    initial begin
        for (int i = 0; i < 128; i++) begin
            regs[i] = 32'h5a5a5a5a;
        end
    end
    // A shown writeback lands in the register file at the edge
    always @(posedge sys_clk) begin
        if (wb_a.valid) regs[wb_a.dest] <= wb_a.data;
        if (wb_b.valid) regs[wb_b.dest] <= wb_b.data;
        if (wb_c.valid) regs[wb_c.dest] <= wb_c.data;
    end
endmodule : fpm_regfile_model

/* testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fpm_pkg::*;
    typedef struct {
        logic [7:0] op;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] res;
        logic [6:0] fl;
    } fpm_row_t;
    logic sys_clk, rst_n, status_write_valid;
    fpm_issue_t issue_slot2, issue_slot3;
    logic [1:0] rounding_mode;
    logic [6:0] status_write_flags, other_unit_flags, exception_flags;
    fpm_wb_t mul_wb_slot2, mul_wb_slot3, cmp_wb;
    int fail_count = 0;
    int compares = 0;
    // Product rows first; the denormal compare last since its flag sticks
    fpm_row_t rows [12] = '{
        '{8'h8f, 32'hc0400000, 32'h3f800000, 32'h00, 7'h00},
        '{8'h8f, 32'h3f000000, 32'h00800000, 32'h46, 7'h00},
        '{8'h8f, 32'h7f800000, 32'h00000000, 32'h10, 7'h00},
        '{8'h8f, 32'h40400000, 32'h00400000, 32'h20, 7'h00},
        '{8'h8f, 32'h00c00000, 32'h80800000, 32'h06, 7'h00},
        '{8'h8f, 32'h7f7fffff, 32'h7f7fffff, 32'h0a, 7'h00},
        '{8'h8f, 32'h00800000, 32'h00800000, 32'h06, 7'h00},
        '{8'h96, 32'h40400000, 32'h00000000, 32'h01, 7'h00},
        '{8'h96, 32'h40400000, 32'h40400000, 32'h00, 7'h00},
        '{8'h96, 32'h40400000, 32'h7fffffff, 32'h00, 7'h00},
        '{8'h96, 32'h7f800000, 32'hff800000, 32'h01, 7'h00},
        '{8'h96, 32'h3f800000, 32'h00400000, 32'h01, 7'h20}};
    fpm_mul_neq_unit fpm_mul_neq_unit_inst (
        .sys_clk, .rst_n, .issue_slot2, .issue_slot3, .rounding_mode,
        .status_write_valid, .status_write_flags, .other_unit_flags,
        .mul_wb_slot2, .mul_wb_slot3, .cmp_wb, .exception_flags);
    fpm_regfile_model fpm_regfile_model_inst (
        .sys_clk, .wb_a(mul_wb_slot2), .wb_b(mul_wb_slot3), .wb_c(cmp_wb));
    // Free running 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    // One issue in slot 3; returns at the falling edge after the take
    task automatic issue(input logic [7:0] op, input logic [31:0] a, b,
            input logic [6:0] d, input logic gd, gl);
        @(negedge sys_clk);
        issue_slot3 = '{1'b1, op, gd, gl, a, b, d};
        @(negedge sys_clk);
        issue_slot3.valid = 1'b0;
    endtask : issue
    task automatic status_write(input logic [6:0] v);
        @(negedge sys_clk);
        status_write_valid = 1'b1;
        status_write_flags = v;
        @(negedge sys_clk);
        status_write_valid = 1'b0;
    endtask : status_write
    task automatic print_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    // Main sequence, inputs change on the falling edge
    initial begin
        fpm_wb_t wb;
        int lat;
        rst_n = 1'b0;
        issue_slot2 = '0;
        issue_slot3 = '0;
        rounding_mode = FPM_RM_NEAREST;
        status_write_valid = 1'b0;
        status_write_flags = 7'h00;
        other_unit_flags = 7'h00;
        repeat (20) @(negedge sys_clk);
        check(exception_flags, 7'h00); // Reset
        check(mul_wb_slot3.valid, 1'b0); // Reset
        rst_n = 1'b1;
        $display("test reset done");
        // Unguarded rows: latency fixed by the opcode
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].a, rows[i].b, 7'(i), 1'b0, 1'b0);
            lat = rows[i].op == FPM_OPC_MUL_FLAGS ? FPM_MUL_LATENCY : 1;
            repeat (lat - 1) @(negedge sys_clk);
            wb = (lat == 1) ? cmp_wb : mul_wb_slot3;
            check(wb.valid, 1'b1); // Timing
            check(wb.data, rows[i].res); // Result
            check(exception_flags, rows[i].fl); // Flags
        end
        $display("test rows done");
        status_write(7'h00);
        check(exception_flags, 7'h00); // Clear
        issue(FPM_OPC_NOT_EQUAL, 32'h3f800000, 32'h00400000, 7'd100, 1, 0);
        check(cmp_wb.valid, 1'b0); // No result
        check(exception_flags, 7'h00); // No flag
        issue(FPM_OPC_MUL_FLAGS, 32'h40400000, 32'h00800000, 7'd101, 1, 0);
        repeat (2) @(negedge sys_clk);
        check(mul_wb_slot3.valid, 1'b0); // No result
        check(fpm_regfile_model_inst.regs[101], 32'h5a5a5a5a);
        $display("test guard done");
        // Both slots together, then slot 2 back to back
        rounding_mode = FPM_RM_ZERO;
        issue_slot2 = '{1'b1, 8'h8f, 1'b1, 1'b1, 32'h7f7fffff, 32'h7f7fffff,
            7'd20};
        issue_slot3 = '{1'b1, 8'h8f, 1'b0, 1'b0, 32'h3f000000, 32'h00800000,
            7'd21};
        @(negedge sys_clk);
        issue_slot3.valid = 1'b0;
        issue_slot2.src1 = 32'h00800000;
        issue_slot2.src2 = 32'h00800000;
        @(negedge sys_clk);
        issue_slot2.valid = 1'b0;
        @(negedge sys_clk);
        check(mul_wb_slot2.valid, 1'b1); // Timing
        check(mul_wb_slot2.data, 32'h0a); // Overflow
        check(mul_wb_slot3.data, 32'h46); // Tiny
        @(negedge sys_clk);
        check(mul_wb_slot2.data, 32'h06); // Back to back
        check(exception_flags, 7'h00); // Untouched
        $display("test slots done");
        // Write, other unit and compare all in one cycle
        status_write_valid = 1'b1;
        status_write_flags = 7'h02;
        other_unit_flags = 7'h08;
        issue_slot3 = '{1'b1, 8'h96, 1'b1, 1'b1, 32'h3f800000, 32'h00400000,
            7'd30};
        @(negedge sys_clk);
        status_write_valid = 1'b0;
        other_unit_flags = 7'h00;
        issue_slot3.valid = 1'b0;
        check(cmp_wb.data, 32'h01); // Differ
        check(exception_flags, 7'h2a); // Merge
        @(negedge sys_clk);
        check(exception_flags, 7'h2a); // Sticky
        $display("test flags done");
        // Reset in mid-run drops sticky flags and any product in flight
        issue(FPM_OPC_MUL_FLAGS, 32'h7f7fffff, 32'h7f7fffff, 7'd40, 0, 0);
        rst_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(exception_flags, 7'h00); // Reset
        check(mul_wb_slot3.valid, 1'b0); // Reset
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(fpm_regfile_model_inst.regs[40], 32'h5a5a5a5a);
        $display("test reset again done");
        // Directed rounding away from zero keeps a deep tiny product
        rounding_mode = FPM_RM_PLUS;
        issue(FPM_OPC_MUL_FLAGS, 32'h00800000, 32'h00800000, 7'd41, 0, 0);
        repeat (2) @(negedge sys_clk);
        check(mul_wb_slot3.data, 32'h46); // Mode
        rounding_mode = FPM_RM_MINUS;
        issue(FPM_OPC_MUL_FLAGS, 32'h80800000, 32'h00800000, 7'd42, 0, 0);
        repeat (2) @(negedge sys_clk);
        check(mul_wb_slot3.data, 32'h46); // Mode
        $display("test rounding done");
        print_verdict();
    end
endmodule : testbench
